// ### design/csr_bank_pkg.sv
// Purpose: constants, field layout and carriers for the host CSR bank
// Assumes: 125 MHz system clock, 16-bit host half-word accesses
// Notes:   byte offsets are host byte addresses; A[1] picks the half
//
// How it works
// - Writing one to the run bit starts the general purpose timer.
// - Run bit zero keeps the timer halted and its count frozen.
// - Run bit falling from one to zero forces preload to all ones.
// - Writable 16-bit preload in low bits, reset all ones, loads counter.
// - Live timer value readable in count register, all ones after reset.
// - Timer raises periodic interrupt requests at preload-defined intervals.
// - Swap value all ones: A[1] set maps to low half.
// - Any other swap value: A[1] set maps to high half.
// - Network data always moves low-order half-word first.
// - 32-bit free-running counter from zero, steps at 25 MHz, wraps.
// - First half-word read captures the whole free-running count.
// - Counter may take up to 160 ns to read cleared.
// - Free-running counter keeps counting in every power state.
// - Dropped frame counter adds one per dropped receive frame.
// - The first half-word read of the dropped frame counter clears it; resets zero.
// - Crossing 7FFFFFFF to 80000000 issues a halfway event.
// - Writing one to busy starts an indirect MAC CSR access.
// - Busy stays set until done; read data valid when busy clears.
// - Direction bit set means read, clear means write.
// - Eight-bit address field selects the targeted MAC CSR.
// - 32-bit data register holds value written or returned.
package csr_bank_pkg;

    // ====================================================================
    // Clocking and tick rates
    localparam int CLOCK_FREQ_KHZ = 125000;
    localparam int TICK_FREQ_KHZ  = 25000;
    localparam int TICK_DIV       = CLOCK_FREQ_KHZ / TICK_FREQ_KHZ;
    localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int TIMER_TICK_NS   = 100000;

    // ====================================================================
    // Register byte offsets
    typedef logic [7:0] addr_t;
    localparam addr_t OFS_TIMER_CFG  = 8'h8C;
    localparam addr_t OFS_TIMER_CNT  = 8'h90;
    localparam addr_t OFS_HALF_ORDER = 8'h98;
    localparam addr_t OFS_TICK_CNT   = 8'h9C;
    localparam addr_t OFS_DROP_TALLY = 8'hA0;
    localparam addr_t OFS_MAC_CMD    = 8'hA4;
    localparam addr_t OFS_MAC_DATA   = 8'hA8;
    localparam int    HALF_ADDR_BIT  = 1;

    // ====================================================================
    // Field positions and reset values
    localparam int TIMER_RUN_BIT = 29;
    localparam int CMD_BUSY_BIT  = 31;
    localparam int CMD_DIR_BIT   = 30;
    localparam logic [15:0] PRELOAD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET   = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
    localparam logic [31:0] SWAP_ON       = 32'hFFFF_FFFF;
    localparam logic [31:0] DROP_HALF_LO  = 32'h7FFF_FFFF;
    localparam logic [31:0] DROP_HALF_HI  = 32'h8000_0000;
    localparam logic [31:0] ONE_WORD      = 32'h0000_0001;

    // ====================================================================
    // States and carriers
    typedef enum logic [1:0] {
        MAC_IDLE = 2'b01,
        MAC_WAIT = 2'b10
    } mac_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic        read;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mac_req_s;

endpackage

// ### design/host_timer_counter_csr_bank.sv
// Purpose: host-visible timer, swap, counters and MAC indirect command
// Assumes: host strobes are one-cycle pulses synchronous to clock
// Notes:   all outputs registered; read data appears one cycle after rd
`timescale 1ns/1ps
module host_timer_counter_csr_bank #(
    parameter int TIMER_TICK_CYCLES =
        csr_bank_pkg::TIMER_TICK_NS / csr_bank_pkg::CLOCK_PERIOD_NS
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire csr_bank_pkg::host_req_s  host_req,
    output logic [15:0]                   host_rdata,
    output logic                          host_rvalid,
    input  wire logic                     rx_frame_dropped,
    input  wire logic                     timer_irq_ack,
    output logic                          timer_irq_flag,
    output logic                          drop_halfway_event,
    output csr_bank_pkg::mac_req_s        mac_req,
    output logic                          mac_req_valid,
    input  wire logic                     mac_done,
    input  wire logic [31:0]              mac_rdata,
    input  wire logic                     tx_word_valid,
    input  wire logic [31:0]              tx_word,
    output logic                          tx_word_ready,
    output logic                          tx_half_valid,
    output logic [15:0]                   tx_half,
    input  wire logic                     rx_half_valid,
    input  wire logic [15:0]              rx_half,
    output logic                          rx_word_valid,
    output logic [31:0]                   rx_word
);
    import csr_bank_pkg::*;

    // ====================================================================
    // Helpers
    function automatic logic [31:0] merge_half(input logic [31:0] old,
                                               input logic        hi,
                                               input logic [15:0] data);
        merge_half = hi ? {data, old[15:0]} : {old[31:16], data};
    endfunction

    function automatic logic [15:0] pick_half(input logic [31:0] val,
                                              input logic        hi);
        pick_half = hi ? val[31:16] : val[15:0];
    endfunction

    // ====================================================================
    // Register state
    logic [2:0]  tick_div_q,   tick_div_d;
    logic [31:0] tmr_pre_q,    tmr_pre_d;
    logic        run_q,        run_d;
    logic [15:0] preload_q,    preload_d;
    logic [15:0] count_q,      count_d;
    logic        irq_q,        irq_d;
    logic [31:0] swap_q,       swap_d;
    logic [31:0] fr_q,         fr_d;
    logic [31:0] fr_snap_q,    fr_snap_d;
    logic        fr_pend_q,    fr_pend_d;
    logic [31:0] drop_q,       drop_d;
    logic [31:0] drop_snap_q,  drop_snap_d;
    logic        drop_pend_q,  drop_pend_d;
    logic        half_evt_q,   half_evt_d;
    mac_state_e  mac_state_q,  mac_state_d;
    logic        dir_q,        dir_d;
    logic [7:0]  cmd_addr_q,   cmd_addr_d;
    logic [31:0] mac_data_q,   mac_data_d;
    mac_req_s    mac_req_q,    mac_req_d;
    logic        mac_vld_q,    mac_vld_d;
    logic [15:0] rdata_q,      rdata_d;
    logic        rvalid_q,     rvalid_d;

    logic        hi_sel;
    logic [5:0]  wsel;
    logic        fr_tick;
    logic        tmr_tick;
    logic [31:0] cfg_new;
    logic [31:0] cmd_new;
    logic [31:0] drop_inc;

    // ====================================================================
    // Next-state for all host registers
    always_comb begin
        hi_sel   = host_req.addr[HALF_ADDR_BIT] ^ (swap_q == SWAP_ON);
        wsel     = host_req.addr[7:2];
        fr_tick  = (tick_div_q == TICK_LAST);
        tmr_tick = run_q && (tmr_pre_q == 32'(TIMER_TICK_CYCLES - 1));
        cfg_new  = merge_half({2'b00, run_q, 13'h0000, preload_q},
                              hi_sel, host_req.wdata);
        cmd_new  = merge_half({mac_state_q == MAC_WAIT, dir_q, 22'h000000,
                               cmd_addr_q}, hi_sel, host_req.wdata);
        drop_inc = drop_q + ONE_WORD;

        tick_div_d  = fr_tick ? 3'b000 : tick_div_q + 3'b001;
        tmr_pre_d   = (tmr_tick || !run_q) ? WORD_ZERO : tmr_pre_q + ONE_WORD;
        run_d       = run_q;
        preload_d   = preload_q;
        count_d     = count_q;
        irq_d       = irq_q && !timer_irq_ack;
        swap_d      = swap_q;
        // counts at 25 MHz, never gated by power state
        fr_d        = fr_tick ? fr_q + ONE_WORD : fr_q;
        fr_snap_d   = fr_snap_q;
        fr_pend_d   = fr_pend_q;
        drop_d      = rx_frame_dropped ? drop_inc : drop_q;
        drop_snap_d = drop_snap_q;
        drop_pend_d = drop_pend_q;
        mac_state_d = mac_state_q;
        dir_d       = dir_q;
        cmd_addr_d  = cmd_addr_q;
        mac_data_d  = mac_data_q;
        mac_req_d   = mac_req_q;
        mac_vld_d   = 1'b0;
        rdata_d     = rdata_q;
        rvalid_d    = host_req.rd;

        // decrement per tick, reload and flag on wrap
        if (tmr_tick) begin
            if (count_q == COUNT_ZERO) begin
                count_d = preload_q;
                irq_d   = 1'b1;
            end else begin
                count_d = count_q - 16'h0001;
            end
        end

        // Host writes
        if (host_req.wr) begin
            case (wsel)
                OFS_TIMER_CFG[7:2]: begin
                    run_d     = cfg_new[TIMER_RUN_BIT];
                    preload_d = cfg_new[15:0];
                    if (!run_q && run_d) begin
                        count_d = preload_d;
                    end
                    if (run_q && !run_d) begin
                        preload_d = PRELOAD_RESET;
                    end
                end
                OFS_HALF_ORDER[7:2]: begin
                    swap_d = merge_half(swap_q, hi_sel, host_req.wdata);
                end
                OFS_MAC_CMD[7:2]: begin
                    // Commands during busy are dropped to protect the access
                    if (mac_state_q == MAC_IDLE) begin
                        dir_d      = cmd_new[CMD_DIR_BIT];
                        cmd_addr_d = cmd_new[7:0];
                        if (cmd_new[CMD_BUSY_BIT]) begin
                            mac_state_d = MAC_WAIT;
                            mac_vld_d   = 1'b1;
                            mac_req_d   = '{read:  cmd_new[CMD_DIR_BIT],
                                            addr:  cmd_new[7:0],
                                            wdata: mac_data_q};
                        end
                    end
                end
                OFS_MAC_DATA[7:2]: begin
                    if (mac_state_q == MAC_IDLE) begin
                        mac_data_d = merge_half(mac_data_q, hi_sel,
                                                host_req.wdata);
                    end
                end
                default: begin
                    mac_data_d = mac_data_q;
                end
            endcase
        end

        // busy clears on done, read data captured on the same edge
        case (mac_state_q)
            MAC_WAIT: begin
                if (mac_done) begin
                    mac_state_d = MAC_IDLE;
                    // returned value lands in data register
                    if (dir_q) begin
                        mac_data_d = mac_rdata;
                    end
                end
            end
            default: begin
                mac_state_d = mac_state_d;
            end
        endcase

        // Host reads, unmapped reads return zero
        if (host_req.rd) begin
            case (wsel)
                OFS_TIMER_CFG[7:2]: rdata_d = pick_half(
                    {2'b00, run_q, 13'h0000, preload_q}, hi_sel);
                OFS_TIMER_CNT[7:2]: rdata_d = pick_half(
                    {16'h0000, count_q}, hi_sel);
                OFS_HALF_ORDER[7:2]: rdata_d = pick_half(swap_q, hi_sel);
                OFS_TICK_CNT[7:2]: begin
                    // first read snapshots the whole count
                    if (!fr_pend_q) begin
                        fr_snap_d = fr_q;
                        rdata_d   = pick_half(fr_q, hi_sel);
                        fr_pend_d = 1'b1;
                    end else begin
                        rdata_d   = pick_half(fr_snap_q, hi_sel);
                        fr_pend_d = 1'b0;
                    end
                end
                OFS_DROP_TALLY[7:2]: begin
                    if (!drop_pend_q) begin
                        drop_snap_d = drop_q;
                        rdata_d     = pick_half(drop_q, hi_sel);
                        drop_pend_d = 1'b1;
                        // clear on read, a same-cycle drop survives
                        drop_d      = rx_frame_dropped ? ONE_WORD : WORD_ZERO;
                    end else begin
                        rdata_d     = pick_half(drop_snap_q, hi_sel);
                        drop_pend_d = 1'b0;
                    end
                end
                OFS_MAC_CMD[7:2]: rdata_d = pick_half(
                    {mac_state_q == MAC_WAIT, dir_q, 22'h000000, cmd_addr_q},
                    hi_sel);
                OFS_MAC_DATA[7:2]: rdata_d = pick_half(mac_data_q, hi_sel);
                default: rdata_d = COUNT_ZERO;
            endcase
        end

        half_evt_d = (drop_q == DROP_HALF_LO) && (drop_d == DROP_HALF_HI);
    end

    // async reset clears the count at once, well inside 160 ns
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick_div_q  <= 3'b000;
            tmr_pre_q   <= WORD_ZERO;
            run_q       <= 1'b0;
            preload_q   <= PRELOAD_RESET;
            count_q     <= COUNT_RESET;
            irq_q       <= 1'b0;
            swap_q      <= WORD_ZERO;
            fr_q        <= WORD_ZERO;
            fr_snap_q   <= WORD_ZERO;
            fr_pend_q   <= 1'b0;
            drop_q      <= WORD_ZERO;
            drop_snap_q <= WORD_ZERO;
            drop_pend_q <= 1'b0;
            half_evt_q  <= 1'b0;
            mac_state_q <= MAC_IDLE;
            dir_q       <= 1'b0;
            cmd_addr_q  <= 8'h00;
            mac_data_q  <= WORD_ZERO;
            mac_req_q   <= '0;
            mac_vld_q   <= 1'b0;
            rdata_q     <= COUNT_ZERO;
            rvalid_q    <= 1'b0;
        end else begin
            tick_div_q  <= tick_div_d;
            tmr_pre_q   <= tmr_pre_d;
            run_q       <= run_d;
            preload_q   <= preload_d;
            count_q     <= count_d;
            irq_q       <= irq_d;
            swap_q      <= swap_d;
            fr_q        <= fr_d;
            fr_snap_q   <= fr_snap_d;
            fr_pend_q   <= fr_pend_d;
            drop_q      <= drop_d;
            drop_snap_q <= drop_snap_d;
            drop_pend_q <= drop_pend_d;
            half_evt_q  <= half_evt_d;
            mac_state_q <= mac_state_d;
            dir_q       <= dir_d;
            cmd_addr_q  <= cmd_addr_d;
            mac_data_q  <= mac_data_d;
            mac_req_q   <= mac_req_d;
            mac_vld_q   <= mac_vld_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
        end
    end

    // ====================================================================
    // Network half-word ordering
    logic [31:0] tx_buf_q,  tx_buf_d;
    logic        tx_full_q, tx_full_d;
    logic        tx_hi_q,   tx_hi_d;
    logic        txv_q,     txv_d;
    logic [15:0] txh_q,     txh_d;
    logic        txr_q,     txr_d;
    logic        rx_have_q, rx_have_d;
    logic [15:0] rx_low_q,  rx_low_d;
    logic        rxv_q,     rxv_d;
    logic [31:0] rxw_q,     rxw_d;

    // low half first both ways; swap never touches this path
    always_comb begin
        tx_buf_d  = tx_buf_q;
        tx_full_d = tx_full_q;
        tx_hi_d   = tx_hi_q;
        txv_d     = 1'b0;
        txh_d     = txh_q;
        rx_have_d = rx_have_q;
        rx_low_d  = rx_low_q;
        rxv_d     = 1'b0;
        rxw_d     = rxw_q;
        if (tx_full_q) begin
            txv_d     = 1'b1;
            txh_d     = tx_hi_q ? tx_buf_q[31:16] : tx_buf_q[15:0];
            tx_hi_d   = !tx_hi_q;
            tx_full_d = !tx_hi_q;
        end else if (tx_word_valid && txr_q) begin
            tx_buf_d  = tx_word;
            tx_full_d = 1'b1;
        end
        txr_d = !tx_full_d;
        if (rx_half_valid) begin
            if (!rx_have_q) begin
                rx_low_d  = rx_half;
                rx_have_d = 1'b1;
            end else begin
                rxw_d     = {rx_half, rx_low_q};
                rxv_d     = 1'b1;
                rx_have_d = 1'b0;
            end
        end
    end

    // Data path registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_buf_q  <= WORD_ZERO;
            tx_full_q <= 1'b0;
            tx_hi_q   <= 1'b0;
            txv_q     <= 1'b0;
            txh_q     <= COUNT_ZERO;
            txr_q     <= 1'b1;
            rx_have_q <= 1'b0;
            rx_low_q  <= COUNT_ZERO;
            rxv_q     <= 1'b0;
            rxw_q     <= WORD_ZERO;
        end else begin
            tx_buf_q  <= tx_buf_d;
            tx_full_q <= tx_full_d;
            tx_hi_q   <= tx_hi_d;
            txv_q     <= txv_d;
            txh_q     <= txh_d;
            txr_q     <= txr_d;
            rx_have_q <= rx_have_d;
            rx_low_q  <= rx_low_d;
            rxv_q     <= rxv_d;
            rxw_q     <= rxw_d;
        end
    end

    // Outputs straight from flip-flops
    assign host_rdata         = rdata_q;
    assign host_rvalid        = rvalid_q;
    assign timer_irq_flag     = irq_q;
    assign drop_halfway_event = half_evt_q;
    assign mac_req            = mac_req_q;
    assign mac_req_valid      = mac_vld_q;
    assign tx_word_ready      = txr_q;
    assign tx_half_valid      = txv_q;
    assign tx_half            = txh_q;
    assign rx_word_valid      = rxv_q;
    assign rx_word            = rxw_q;

endmodule

// ### testbench/mac_csr_partner.sv
// Purpose: MAC CSR space seen through the indirect command port
// Assumes: one request at a time, answered lag+1 clocks after it arrives
// Notes:   read data is scrambled whenever no answer is due
`timescale 1ns/1ps
module mac_csr_partner
    import csr_bank_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire mac_req_s    mac_req,
    input  wire logic        mac_req_valid,
    input  wire logic [3:0]  lag,
    output logic             mac_done,
    output logic [31:0]      mac_rdata
);
    logic [31:0] mem [256];
    logic [31:0] rd_q;
    logic [3:0]  cnt;
    logic        busy;
    // ========================================================
    // Preset pattern so reads of untouched CSRs are recognisable
    initial for (int i = 0; i < 256; i++) mem[i] = 32'h5A00_0000 | i;
    // direction, address and data of one access
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            mac_done <= 1'b0;
            cnt <= 4'h0;
        end else begin
            mac_done <= 1'b0;
            if (mac_req_valid) begin
                busy <= 1'b1;
                cnt <= lag;
                rd_q <= mem[mac_req.addr];
                if (!mac_req.read) mem[mac_req.addr] <= mac_req.wdata;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                mac_done <= 1'b1;
            end else if (busy) cnt <= cnt - 4'h1;
        end
    end
    // Inverse outside the answer, so a late sample never matches
    assign mac_rdata = mac_done ? rd_q : ~rd_q;
endmodule

// ### testbench/csr_bank_assertions.sv
// Purpose: port timing checks for the CSR bank
// Assumes: single clock, async active-high reset
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
module csr_bank_checker
    import csr_bank_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire host_req_s   host_req,
    input wire logic        host_rvalid,
    input wire logic        rx_frame_dropped,
    input wire logic        timer_irq_ack,
    input wire logic        timer_irq_flag,
    input wire logic        drop_halfway_event,
    input wire mac_req_s    mac_req,
    input wire logic        mac_req_valid,
    input wire logic        tx_word_valid,
    input wire logic [31:0] tx_word,
    input wire logic        tx_word_ready,
    input wire logic        tx_half_valid,
    input wire logic [15:0] tx_half,
    input wire logic        rx_half_valid,
    input wire logic [15:0] rx_half,
    input wire logic        rx_word_valid,
    input wire logic [31:0] rx_word
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ========================================================
    // Host side and counters
    a_read_answered: assert property (
        host_req.rd |=> host_rvalid) else $error("read not answered");
    a_flag_sticky: assert property (
        timer_irq_flag && !timer_irq_ack |=> timer_irq_flag)
        else $error("timer flag lost");
    a_halfway_cause: assert property (
        drop_halfway_event |-> $past(rx_frame_dropped))
        else $error("halfway without drop");
    a_halfway_pulse: assert property (
        drop_halfway_event |=> !drop_halfway_event)
        else $error("halfway not a pulse");
    // ========================================================
    // Indirect access and network order
    a_mac_from_write: assert property (
        mac_req_valid |-> $past(host_req.wr) && $past(host_req.wdata[15]))
        else $error("stray access");
    a_mac_one_shot: assert property (
        mac_req_valid |=> !mac_req_valid) else $error("access repeated");
    a_mac_req_held: assert property (
        mac_req_valid |=> $stable(mac_req)) else $error("request moved");
    a_tx_low_first: assert property (
        tx_word_valid && tx_word_ready |-> ##2
        tx_half_valid && tx_half == $past(tx_word[15:0], 2) ##1
        tx_half_valid && tx_half == $past(tx_word[31:16], 3))
        else $error("transmit order");
    a_rx_low_first: assert property (
        rx_word_valid |-> $past(rx_half_valid) &&
        rx_word[31:16] == $past(rx_half)) else $error("receive order");
endmodule
bind host_timer_counter_csr_bank csr_bank_checker i_csr_bank_checker (
    .clock(clock), .sys_rst(sys_rst), .host_req(host_req),
    .host_rvalid(host_rvalid), .rx_frame_dropped(rx_frame_dropped),
    .timer_irq_ack(timer_irq_ack), .timer_irq_flag(timer_irq_flag),
    .drop_halfway_event(drop_halfway_event), .mac_req(mac_req),
    .mac_req_valid(mac_req_valid), .tx_word_valid(tx_word_valid),
    .tx_word(tx_word), .tx_word_ready(tx_word_ready),
    .tx_half_valid(tx_half_valid), .tx_half(tx_half),
    .rx_half_valid(rx_half_valid), .rx_half(rx_half),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word));

// ### testbench/test_host_timer_counter_csr_bank.sv
// Purpose: register-level tests of the CSR bank
// Assumes: timer tick shortened to 3 clocks
// Notes:   expectations worked out here, except count held and snapshot, which compare with earlier reads
`timescale 1ns/1ps
module test_host_timer_counter_csr_bank;
    import csr_bank_pkg::*;
    logic clock, sys_rst, drop, ack, done, rv, flag, hw, mv;
    logic txv, txr, thv, rxv, rwv;
    logic [15:0] rdata, th, rxh, d, v1, v2, v3;
    logic [31:0] mrd, txw, rw;
    logic [3:0] lag = 4'h6;
    host_req_s hq;
    mac_req_s mq;
    int errors, checks, cyc, n;
    host_timer_counter_csr_bank #(.TIMER_TICK_CYCLES(3))
        i_host_timer_counter_csr_bank (.clock(clock), .sys_rst(sys_rst),
        .host_req(hq), .host_rdata(rdata), .host_rvalid(rv),
        .rx_frame_dropped(drop), .timer_irq_ack(ack),
        .timer_irq_flag(flag), .drop_halfway_event(hw), .mac_req(mq),
        .mac_req_valid(mv), .mac_done(done), .mac_rdata(mrd),
        .tx_word_valid(txv), .tx_word(txw), .tx_word_ready(txr),
        .tx_half_valid(thv), .tx_half(th), .rx_half_valid(rxv),
        .rx_half(rxh), .rx_word_valid(rwv), .rx_word(rw));
    mac_csr_partner i_mac_csr_partner (.clock(clock), .sys_rst(sys_rst),
        .mac_req(mq), .mac_req_valid(mv), .lag(lag), .mac_done(done),
        .mac_rdata(mrd));
    // ========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input addr_t a, input logic [15:0] w);
        @(posedge clock); #1;
        hq = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: w};
        @(posedge clock); #1;
        hq.wr = 1'b0;
    endtask
    task automatic rd(input addr_t a, output logic [15:0] q);
        @(posedge clock); #1;
        hq = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 16'h0000};
        @(posedge clock); #1;
        hq.rd = 1'b0;
        chk("read valid", {31'h0, rv}, 32'h1);
        q = rdata;
    endtask
    task automatic rc(input string nm, input addr_t a, logic [15:0] e);
        logic [15:0] q;
        rd(a, q);
        chk(nm, {16'h0, q}, {16'h0, e});
    endtask
    task automatic idle();
        logic [15:0] q;
        q = 16'h8000;
        for (int i = 0; i < 40 && q[15] !== 1'b0; i++) rd(8'hA6, q);
        chk("busy", {31'h0, q[15]}, 32'h0);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end
    // ========================================================
    // Test sequence
    initial begin
        {sys_rst, drop, ack, txv, rxv} = 5'b10000;
        {hq, txw, rxh, errors, checks, cyc} = '0;
        repeat (6) @(posedge clock);
        #1 sys_rst = 1'b0;
        rc("preload", 8'h8C, 16'hFFFF);
        rc("run", 8'h8E, 16'h0000);
        rc("count", 8'h90, 16'hFFFF);
        rc("swap", 8'h98, 16'h0000);
        rc("drops lo", 8'hA0, 16'h0000);
        rc("drops hi", 8'hA2, 16'h0000);
        rc("command", 8'hA6, 16'h0000);
        rc("data", 8'hA8, 16'h0000);
        rc("unmapped", 8'h80, 16'h0000);
        $display("reset values done");
        wr(8'h8C, 16'h0003);
        rc("preload", 8'h8C, 16'h0003);
        rc("halted", 8'h90, 16'hFFFF);
        wr(8'h8E, 16'h2000);
        for (n = 0; n < 100 && flag !== 1'b1; n++) @(posedge clock);
        chk("timer flag", {31'h0, flag}, 32'h1);
        rd(8'h90, d);
        chk("count run", {31'h0, d <= 16'h0003}, 32'h1);
        wr(8'h8E, 16'h0000);
        rc("preload stop", 8'h8C, 16'hFFFF);
        rd(8'h90, d);
        repeat (10) @(posedge clock);
        rc("count held", 8'h90, d);
        @(posedge clock); #1 ack = 1'b1;
        @(posedge clock); #1 ack = 1'b0;
        chk("flag ack", {31'h0, flag}, 32'h0);
        $display("timer done");
        rd(8'h9C, v1);
        repeat (21) @(posedge clock);
        rd(8'h9C, v2);
        rd(8'h9C, v3);
        chk("snapshot", {16'h0, v2}, {16'h0, v1});
        chk("advance", {16'h0, 16'(v3 - v1)}, 32'h5);
        rc("free hi", 8'h9E, 16'h0000);
        $display("free run done");
        wr(8'h98, 16'hFFFF);
        wr(8'h9A, 16'hFFFF);
        rc("swap set", 8'h98, 16'hFFFF);
        wr(8'h8E, 16'h1234);
        rc("swapped lo", 8'h8E, 16'h1234);
        rc("swapped hi", 8'h8C, 16'h0000);
        wr(8'h98, 16'h0000);
        rc("other swap", 8'h8C, 16'h1234);
        $display("swap done");
        repeat (3) begin
            @(posedge clock); #1 drop = 1'b1;
            @(posedge clock); #1 drop = 1'b0;
        end
        rc("drops", 8'hA0, 16'h0003);
        rc("drops hi", 8'hA2, 16'h0000);
        rc("cleared", 8'hA0, 16'h0000);
        rc("cleared hi", 8'hA2, 16'h0000);
        $display("drop count done");
        wr(8'hA8, 16'hBEEF);
        wr(8'hAA, 16'h1234);
        wr(8'hA4, 16'h0042);
        wr(8'hA6, 16'h8000);
        rc("busy set", 8'hA6, 16'h8000);
        wr(8'hA8, 16'h0000);
        idle();
        chk("mac write", i_mac_csr_partner.mem[8'h42], 32'h1234_BEEF);
        rc("data kept", 8'hA8, 16'hBEEF);
        lag = 4'h0;
        wr(8'hA4, 16'h0007);
        wr(8'hA6, 16'hC000);
        idle();
        rc("mac rd lo", 8'hA8, 16'h0007);
        rc("mac rd hi", 8'hAA, 16'h5A00);
        $display("indirect access done");
        @(posedge clock); #1 {txv, txw} = {1'b1, 32'hA1B2_C3D4};
        @(posedge clock); #1 txv = 1'b0;
        @(posedge clock); #1;
        chk("tx first", {thv, 15'h0, th}, 32'h8000_C3D4);
        @(posedge clock); #1 rxv = 1'b1;
        chk("tx second", {thv, 15'h0, th}, 32'h8000_A1B2);
        rxh = 16'h5566;
        @(posedge clock); #1 rxh = 16'h7788;
        @(posedge clock); #1 rxv = 1'b0;
        chk("rx valid", {31'h0, rwv}, 32'h1);
        chk("rx word", rw, 32'h7788_5566);
        $display("network order done");
        test_done();
    end
endmodule
